// ==== core/dfb_top.sv ====
// Feedback divider and loop bandwidth register bank for the digital PLL
//
// Chosen here: the strobed register port and the placing of the registers.
module dfb_top
(
   input  wire logic                        clk_sys,
   input  wire logic                        nrst,
   input  wire logic [dfb_pkg::ADDR_W-1:0]  bus_addr,
   input  wire logic [dfb_pkg::DATA_W-1:0]  bus_wdata,
   input  wire logic                        bus_wr,
   input  wire logic                        bus_rd,
   output logic      [dfb_pkg::DATA_W-1:0]  bus_rdata,
   input  wire logic                        ref_select,
   input  wire logic                        phase_locked,
   output logic      [dfb_pkg::RATIO_W-1:0] fb_ratio,
   output logic      [dfb_pkg::BW_W-1:0]    loop_bandwidth,
   output logic                             bw_acquire_active
);
   import dfb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [RATIO_W-1:0] feedback_ratio_ref0_reg;
   logic [RATIO_W-1:0] feedback_ratio_ref1_reg;
   logic [BW_W-1:0]    locked_bandwidth_select_reg;
   logic [BW_W-1:0]    acquire_bandwidth_select_reg;
   logic               quick_acquire_enable_reg;
   logic [DATA_W-1:0]  rdata_next;
   logic [RATIO_W-1:0] ratio_next;
   logic [BW_W-1:0]    bw_next;
   dfb_bw_sel_t        bw_sel_next;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   wire wr_r0_hi = bus_wr && (bus_addr == ADDR_RATIO0_HI);
   wire wr_r0_md = bus_wr && (bus_addr == ADDR_RATIO0_MD);
   wire wr_r0_lo = bus_wr && (bus_addr == ADDR_RATIO0_LO);
   wire wr_r1_hi = bus_wr && (bus_addr == ADDR_RATIO1_HI);
   wire wr_r1_md = bus_wr && (bus_addr == ADDR_RATIO1_MD);
   wire wr_r1_lo = bus_wr && (bus_addr == ADDR_RATIO1_LO);
   wire wr_bw    = bus_wr && (bus_addr == ADDR_BANDWIDTH);
   wire wr_ctrl  = bus_wr && (bus_addr == ADDR_LOOP_CTRL);

   // Reserved bandwidth codes are dropped so the loop never sees them
   wire [BW_W-1:0] wr_lck_code = bus_wdata[LCK_BW_LSB +: BW_W];
   wire [BW_W-1:0] wr_acq_code = bus_wdata[ACQ_BW_LSB +: BW_W];
   wire wr_lck_ok = wr_bw && (wr_lck_code != BW_RESERVED);
   wire wr_acq_ok = wr_bw && (wr_acq_code != BW_RESERVED);

   ////////////////////////////////////////////////////////////////////////////
   // Bandwidth and ratio selection toward the PLL core
   assign bw_sel_next = (quick_acquire_enable_reg && !phase_locked)
                        ? DFB_BW_ACQUIRE : DFB_BW_LOCKED;
   assign bw_next = (bw_sel_next == DFB_BW_ACQUIRE)
                    ? acquire_bandwidth_select_reg
                    : locked_bandwidth_select_reg;
   assign ratio_next = ref_select ? feedback_ratio_ref1_reg
                                  : feedback_ratio_ref0_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb
   begin
      rdata_next = READ_ZERO;
      if (bus_rd)
      begin
         case (bus_addr)
            ADDR_RATIO0_HI: rdata_next = feedback_ratio_ref0_reg[23:16];
            ADDR_RATIO0_MD: rdata_next = feedback_ratio_ref0_reg[15:8];
            ADDR_RATIO0_LO: rdata_next = feedback_ratio_ref0_reg[7:0];
            ADDR_RATIO1_HI: rdata_next = feedback_ratio_ref1_reg[23:16];
            ADDR_RATIO1_MD: rdata_next = feedback_ratio_ref1_reg[15:8];
            ADDR_RATIO1_LO: rdata_next = feedback_ratio_ref1_reg[7:0];
            ADDR_BANDWIDTH: rdata_next = {locked_bandwidth_select_reg,
                                          acquire_bandwidth_select_reg};
            ADDR_LOOP_CTRL: rdata_next[QUICK_ACQ_BIT] =
                               quick_acquire_enable_reg;
            ADDR_STATUS:
            begin
               rdata_next[ST_ACQ_BIT]  = bw_acquire_active;
               rdata_next[ST_REF_BIT]  = ref_select;
               rdata_next[ST_LOCK_BIT] = phase_locked;
            end
            default: rdata_next = READ_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Feedback ratio bytes
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         feedback_ratio_ref0_reg <= RATIO_RESET;
         feedback_ratio_ref1_reg <= RATIO_RESET;
      end
      else
      begin
         if (wr_r0_hi) feedback_ratio_ref0_reg[23:16] <= bus_wdata;
         if (wr_r0_md) feedback_ratio_ref0_reg[15:8]  <= bus_wdata;
         if (wr_r0_lo) feedback_ratio_ref0_reg[7:0]   <= bus_wdata;
         if (wr_r1_hi) feedback_ratio_ref1_reg[23:16] <= bus_wdata;
         if (wr_r1_md) feedback_ratio_ref1_reg[15:8]  <= bus_wdata;
         if (wr_r1_lo) feedback_ratio_ref1_reg[7:0]   <= bus_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bandwidth codes and quick acquire enable
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         locked_bandwidth_select_reg  <= BW_RESET;
         acquire_bandwidth_select_reg <= BW_RESET;
         quick_acquire_enable_reg     <= QUICK_ACQ_RESET;
      end
      else
      begin
         if (wr_lck_ok) locked_bandwidth_select_reg  <= wr_lck_code;
         if (wr_acq_ok) acquire_bandwidth_select_reg <= wr_acq_code;
         if (wr_ctrl)   quick_acquire_enable_reg <= bus_wdata[QUICK_ACQ_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         bus_rdata         <= READ_ZERO;
         fb_ratio          <= RATIO_RESET;
         loop_bandwidth    <= BW_RESET;
         bw_acquire_active <= 1'b0;
      end
      else
      begin
         bus_rdata         <= rdata_next;
         fb_ratio          <= ratio_next;
         loop_bandwidth    <= bw_next;
         bw_acquire_active <= (bw_sel_next == DFB_BW_ACQUIRE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // A ratio byte write lands in storage at the next edge
   a_ratio0_write: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      wr_r0_lo |=> (feedback_ratio_ref0_reg[7:0] == $past(bus_wdata)))
      else $error("ratio 0 low byte not stored");

   a_ratio1_write: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      wr_r1_hi |=> (feedback_ratio_ref1_reg[23:16] == $past(bus_wdata)))
      else $error("ratio 1 high byte not stored");

   // Read data carry the byte stored when the strobe was taken
   a_ratio0_readback: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (bus_rd && bus_addr == ADDR_RATIO0_MD) |=>
      (bus_rdata == $past(feedback_ratio_ref0_reg[15:8])))
      else $error("ratio 0 middle byte read back wrong");

   a_ratio1_readback: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (bus_rd && bus_addr == ADDR_RATIO1_HI) |=>
      (bus_rdata == $past(feedback_ratio_ref1_reg[23:16])))
      else $error("ratio 1 high byte read back wrong");

   // Reserved codes never reach storage and leave the old code in place
   a_lck_no_reserved: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      locked_bandwidth_select_reg != BW_RESERVED)
      else $error("locked bandwidth holds reserved code");

   a_lck_kept: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (wr_bw && wr_lck_code == BW_RESERVED) |=>
      $stable(locked_bandwidth_select_reg))
      else $error("reserved locked code changed storage");

   a_acq_no_reserved: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      acquire_bandwidth_select_reg != BW_RESERVED)
      else $error("acquisition bandwidth holds reserved code");

   a_acq_kept: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (wr_bw && wr_acq_code == BW_RESERVED) |=>
      $stable(acquire_bandwidth_select_reg))
      else $error("reserved acquisition code changed storage");

   // A write right behind the read must not disturb the returned code
   a_acq_readback: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (bus_rd && bus_addr == ADDR_BANDWIDTH) |=>
      (bus_rdata[ACQ_BW_LSB +: BW_W] ==
       $past(acquire_bandwidth_select_reg)))
      else $error("acquisition code read back wrong");

   // Bandwidth toward the loop follows quick acquire and the lock state
   a_bw_follows_lock: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (!quick_acquire_enable_reg && $stable(locked_bandwidth_select_reg))
      |=> (loop_bandwidth == $past(locked_bandwidth_select_reg)))
      else $error("locked bandwidth not applied");

   a_bw_acquire: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (quick_acquire_enable_reg && !phase_locked) |=>
      (bw_acquire_active && loop_bandwidth ==
       $past(acquire_bandwidth_select_reg)))
      else $error("acquisition bandwidth not applied");

   a_bw_locked: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (quick_acquire_enable_reg && phase_locked) |=>
      (!bw_acquire_active && loop_bandwidth ==
       $past(locked_bandwidth_select_reg)))
      else $error("locked bandwidth not applied once locked");

   // Ratio toward the core follows the selected reference
   a_ratio_select: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      ref_select |=> (fb_ratio == $past(feedback_ratio_ref1_reg)))
      else $error("selected ratio not presented");

   a_ratio_ref0: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      !ref_select |=> (fb_ratio == $past(feedback_ratio_ref0_reg)))
      else $error("reference 0 ratio not presented");

endmodule

// ==== core/dfb_pkg.sv ====
// Constants for the PLL feedback divider and loop bandwidth register bank
//
// Summary of operation
// - 24-bit read/write feedback ratio for reference 0, reset to 070000h.
// - 24-bit read/write feedback ratio for reference 1, reset to 070000h.
// - 4-bit locked bandwidth code from 0.2Hz, reset 0111b; 1111 reserved.
// - 4-bit acquire bandwidth code, same table, reset 0111b; 1111 reserved.
// - Quick acquire uses acquire code whenever unlocked, else locked code always.
package dfb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int RATIO_W = 24;
   localparam int BW_W = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Byte addresses
   localparam logic [15:0] ADDR_RATIO0_HI = 16'h0011;
   localparam logic [15:0] ADDR_RATIO0_MD = 16'h0012;
   localparam logic [15:0] ADDR_RATIO0_LO = 16'h0013;
   localparam logic [15:0] ADDR_RATIO1_HI = 16'h0014;
   localparam logic [15:0] ADDR_RATIO1_MD = 16'h0015;
   localparam logic [15:0] ADDR_RATIO1_LO = 16'h0016;
   localparam logic [15:0] ADDR_BANDWIDTH = 16'h0017;
   localparam logic [15:0] ADDR_LOOP_CTRL = 16'h0023;
   localparam logic [15:0] ADDR_STATUS = 16'h0030;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int LCK_BW_LSB = 4;
   localparam int ACQ_BW_LSB = 0;
   localparam int QUICK_ACQ_BIT = 0;
   localparam int ST_ACQ_BIT = 0;
   localparam int ST_REF_BIT = 1;
   localparam int ST_LOCK_BIT = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and reserved code
   localparam logic [23:0] RATIO_RESET = 24'h070000;
   localparam logic [3:0] BW_RESET = 4'h7;
   localparam logic [3:0] BW_RESERVED = 4'hF;
   localparam logic QUICK_ACQ_RESET = 1'h0;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Which bandwidth code drives the loop
   typedef enum logic {DFB_BW_LOCKED, DFB_BW_ACQUIRE} dfb_bw_sel_t;

endpackage

// ==== tb/dfb_top_test.sv ====
// Self-checking testbench for the feedback ratio and bandwidth register bank
module dfb_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dfb_pkg::*;

   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic [15:0] bus_addr = 16'h0000;
   logic [7:0]  bus_wdata = 8'h00;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   logic [7:0]  bus_rdata;
   logic        ref_select = 1'b0;
   logic        phase_locked = 1'b0;
   logic [23:0] fb_ratio;
   logic [3:0]  loop_bandwidth;
   logic        bw_acquire_active;
   int          err_total = 0;
   int          checks = 0;
   int          cycles = 0;

   dfb_top dfb_top_inst (.clk_sys(clk_sys), .nrst(nrst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .ref_select(ref_select),
      .phase_locked(phase_locked), .fb_ratio(fb_ratio),
      .loop_bandwidth(loop_bandwidth),
      .bw_acquire_active(bw_acquire_active));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         err_total++;
         $display("unexpected at %0t: run timed out", $time);
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Verdict, comparisons and bus cycles
   task automatic test_done();
      $display("checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: read %h not %h", $time, got, exp);
      end
   endtask

   task automatic cmp_out(input logic [28:0] got, input logic [28:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: pll side %h not %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1;
      cmp8(bus_rdata, exp);
   endtask

   // Sets the core-side inputs, then checks ratio, acquire flag and code
   task automatic pll(input logic r, input logic l, input logic [23:0] x,
                      input logic a, input logic [3:0] b);
      @(posedge clk_sys);
      ref_select <= r;
      phase_locked <= l;
      repeat (2) @(posedge clk_sys);
      #1;
      cmp_out({fb_ratio, bw_acquire_active, loop_bandwidth}, {x, a, b});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      pll(1'b0, 1'b0, RATIO_RESET, 1'b0, BW_RESET);
      pll(1'b1, 1'b0, RATIO_RESET, 1'b0, BW_RESET);
      rd(ADDR_RATIO0_HI, 8'h07);
      rd(ADDR_RATIO0_LO, 8'h00);
      rd(ADDR_RATIO1_HI, 8'h07);
      rd(ADDR_BANDWIDTH, 8'h77);
      rd(ADDR_LOOP_CTRL, 8'h00);
      $display("reset test done");
   endtask

   task automatic t_ratio();
      logic [7:0] v [6] = '{8'h12, 8'h34, 8'h56, 8'hAB, 8'hCD, 8'hEF};
      for (int i = 0; i < 6; i++)
         wr(ADDR_RATIO0_HI + 16'(i), v[i]);
      rd(ADDR_RATIO0_MD, 8'h34);
      rd(ADDR_RATIO1_LO, 8'hEF);
      pll(1'b0, 1'b1, 24'h123456, 1'b0, BW_RESET);
      pll(1'b1, 1'b1, 24'hABCDEF, 1'b0, BW_RESET);
      $display("ratio test done");
   endtask

   task automatic t_bw();
      for (int i = 0; i < 15; i++)
      begin
         wr(ADDR_BANDWIDTH, {4'(i), 4'(14 - i)});
         rd(ADDR_BANDWIDTH, {4'(i), 4'(14 - i)});
      end
      wr(ADDR_BANDWIDTH, 8'h5A);
      wr(ADDR_BANDWIDTH, 8'hF3);
      rd(ADDR_BANDWIDTH, 8'h53);
      wr(ADDR_BANDWIDTH, 8'h6F);
      rd(ADDR_BANDWIDTH, 8'h63);
      pll(1'b0, 1'b0, 24'h123456, 1'b0, 4'h6);
      wr(ADDR_LOOP_CTRL, 8'h01);
      rd(ADDR_LOOP_CTRL, 8'h01);
      pll(1'b0, 1'b0, 24'h123456, 1'b1, 4'h3);
      rd(ADDR_STATUS, 8'h01);
      pll(1'b1, 1'b1, 24'hABCDEF, 1'b0, 4'h6);
      rd(ADDR_STATUS, 8'h06);
      pll(1'b1, 1'b0, 24'hABCDEF, 1'b1, 4'h3);
      wr(ADDR_LOOP_CTRL, 8'h00);
      rd(ADDR_LOOP_CTRL, 8'h00);
      pll(1'b1, 1'b0, 24'hABCDEF, 1'b0, 4'h6);
      wr(16'h0018, 8'hFF);
      rd(16'h0018, 8'h00);
      rd(ADDR_BANDWIDTH, 8'h63);
      $display("bandwidth test done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset();
      t_ratio();
      t_bw();
      test_done();
   end

endmodule
